// >>> pkg/hmp_defs.svh
`ifndef HMP_DEFS_SVH
`define HMP_DEFS_SVH

// ==========================================
// widths
`define HMP_DATA_W 16
`define HMP_ADDR_W 18

// ==========================================
// register select codes (multiplexed mode)
`define HMP_SEL_CTRL 2'h0
`define HMP_SEL_DATA_INC 2'h1
`define HMP_SEL_ADDR 2'h2
`define HMP_SEL_DATA 2'h3

// ==========================================
// control register bit positions
`define HMP_CTRL_EXT_SEL 0
`define HMP_CTRL_CORE_IRQ 1
`define HMP_CTRL_HOST_IRQ 2
`define HMP_CTRL_PREF_EN 4

// ==========================================
// status register bit positions (addr_reg sits in bits 17..0)
`define HMP_STAT_BUSY 18
`define HMP_STAT_MUX 19
`define HMP_STAT_PREF_VALID 20

// ==========================================
// bus map and answers
`define HMP_OFS_CTRL 32'h0000_0000
`define HMP_OFS_STATUS 32'h0000_0004
`define HMP_ADDR_DEC_MASK 32'h0000_00FC
`define HMP_HSIZE_WORD 3'h2
`define HMP_HTRANS_NONSEQ 2'h2
`define HMP_HRESP_OKAY 1'h0
`define HMP_CTRL_RESET 16'h0000

`endif

// >>> pkg/hmp_pkg.sv
`include "hmp_defs.svh"

package hmp_pkg;

    typedef enum logic [1:0] {
        HMP_IDLE,
        HMP_DMA,
        HMP_DONE
    } hmp_fsm_type;

    // host pins as sampled through the synchroniser
    typedef struct packed {
        logic mux_sel;
        logic cs_n;
        logic ds1_n;
        logic ds2_n;
        logic rw;
        logic as_n;
        logic [1:0] sel;
        logic [`HMP_ADDR_W-1:0] addr;
        logic [`HMP_DATA_W-1:0] data;
    } hmp_pins_type;

    // request to the auxiliary dma channel
    typedef struct packed {
        logic valid;
        logic we;
        logic [`HMP_ADDR_W-1:0] addr;
        logic [`HMP_DATA_W-1:0] wdata;
    } hmp_dma_req_type;

    typedef struct packed {
        hmp_pins_type sync1;
        hmp_pins_type sync2;
        logic strobe_q;
        logic as_q;
        logic [1:0] as_sel;
        logic as_rw;
        logic as_valid;
        hmp_fsm_type fsm;
        logic acc_rw;
        logic [1:0] acc_sel;
        logic acc_inc;
        logic acc_pref;
        logic [`HMP_ADDR_W-1:0] addr_reg;
        logic ext_sel;
        logic pref_en;
        logic host_irq;
        logic core_irq;
        logic pref_valid;
        logic [`HMP_DATA_W-1:0] pref_data;
        logic [`HMP_DATA_W-1:0] out_data;
        logic out_oe;
        hmp_dma_req_type dma;
        logic bus_wr;
        logic [31:0] bus_addr;
        logic [31:0] hrdata;
    } hmp_state_type;

endpackage

// >>> logic/hmp_host_port.sv
`timescale 1ns/1ps
`include "hmp_defs.svh"

// What this block does
// R1: only a memory slave; no processor or dma i/o space is ever addressed
// R2: sixteen-bit two-way data bus, driven on host reads, sampled on writes
// R3: mode-select pin picks multiplexed or separate address and data buses
// R4: separate mode takes an eighteen-bit host address bus
// R5: multiplexed mode keeps an eighteen-bit address register with auto-increment
// R6: multiplexed access starts on strobes and chip select; select, rw, address strobe steer it
// R7: separate mode loads address from its bus; read/write alone sets direction
// R8: control register unreachable by the host in separate mode
// R9: every memory access goes out as a dma read or write
// R10: ready held off while the dma transfer is pending; host waits for it
// R11: host writing one to core-interrupt bit interrupts and wakes the dsp
// R12: core-interrupt bit always reads zero from either side
// R13: dsp writing one to host-interrupt bit asserts the host interrupt pin
// R14: host clears host interrupt by writing one; writing zero does nothing
// R15: host and dsp both reach control: interrupts, extended addressing, prefetch
// R16: in light or deeper sleep, clocks enabled only around each memory access
// R17: own reset releases the port while the dsp core stays in reset
// R18: host accesses go on while the core is halted for emulation
// R19: served by its own auxiliary dma channel, apart from the general ones
// R20: host holds strobe, address and write data steady until ready
// R21: core-interrupt write gives one pulse, no state kept in the bit
module hmp_host_port
    import hmp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic port_mux_select,
    input wire logic host_chip_select_n,
    input wire logic data_strobe_one_n,
    input wire logic data_strobe_two_n,
    input wire logic host_read_write,
    input wire logic host_addr_strobe_n,
    input wire logic [1:0] reg_select_lines,
    input wire logic [`HMP_ADDR_W-1:0] host_addr_bus,
    input wire logic [`HMP_DATA_W-1:0] host_data_bus_in,
    output logic [`HMP_DATA_W-1:0] host_data_bus_out,
    output logic host_data_bus_oe,
    output logic host_wait_ready,
    output logic host_irq_n,
    output logic core_irq_request,
    output hmp_dma_req_type aux_dma_req,
    input wire logic aux_dma_ack,
    input wire logic [`HMP_DATA_W-1:0] aux_dma_rdata,
    input wire logic light_sleep,
    input wire logic deeper_sleep,
    output logic mem_clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);

    hmp_state_type s;
    hmp_state_type next_s;
    hmp_pins_type pins;
    logic strobe;
    logic strobe_rise;
    logic mux_mode;
    logic host_ctrl_wr;
    logic dsp_ctrl_wr;
    logic [`HMP_DATA_W-1:0] ctrl_view;

    // ==========================================
    // pin capture
    always_comb begin
        pins.mux_sel = port_mux_select;
        pins.cs_n = host_chip_select_n;
        pins.ds1_n = data_strobe_one_n;
        pins.ds2_n = data_strobe_two_n;
        pins.rw = host_read_write;
        pins.as_n = host_addr_strobe_n;
        pins.sel = reg_select_lines;
        pins.addr = host_addr_bus;
        pins.data = host_data_bus_in;
    end

    // bus pins are only read after two flops; the host keeps them steady
    // for the whole strobe, so the wide bus settles before it is used
    assign mux_mode = s.sync2.mux_sel; // R3
    assign strobe = !s.sync2.cs_n && (!s.sync2.ds1_n || !s.sync2.ds2_n); // R6 R7
    assign strobe_rise = strobe && !s.strobe_q;

    // core-interrupt bit is never stored, so it always reads as zero
    always_comb begin
        ctrl_view = `HMP_CTRL_RESET;
        ctrl_view[`HMP_CTRL_EXT_SEL] = s.ext_sel;
        ctrl_view[`HMP_CTRL_HOST_IRQ] = s.host_irq;
        ctrl_view[`HMP_CTRL_PREF_EN] = s.pref_en;
        ctrl_view[`HMP_CTRL_CORE_IRQ] = 1'b0; // R12
    end

    // ==========================================
    // next state
    always_comb begin
        next_s = s;
        host_ctrl_wr = 1'b0;
        next_s.sync1 = pins;
        next_s.sync2 = s.sync1;
        next_s.strobe_q = strobe;
        next_s.as_q = !s.sync2.as_n;
        next_s.core_irq = 1'b0; // R21

        // address strobe latches select and direction for hosts that use it
        if (!s.sync2.as_n && !s.as_q) begin // R6
            next_s.as_sel = s.sync2.sel;
            next_s.as_rw = s.sync2.rw;
            next_s.as_valid = 1'b1;
        end

        // the core halt state is never looked at: emulation stops nothing here
        case (s.fsm) // R18
            HMP_IDLE: begin
                if (strobe_rise) begin
                    next_s.as_valid = 1'b0;
                    next_s.acc_inc = 1'b0;
                    next_s.acc_pref = 1'b0;
                    if (!mux_mode) begin // R8
                        // separate buses: direction from read/write only
                        next_s.acc_rw = s.sync2.rw; // R7
                        next_s.acc_sel = `HMP_SEL_DATA;
                        next_s.addr_reg = s.sync2.addr; // R4 R7
                        next_s.pref_valid = 1'b0;
                        next_s.dma.valid = 1'b1; // R9
                        next_s.dma.we = !s.sync2.rw;
                        next_s.dma.addr = s.sync2.addr;
                        next_s.dma.wdata = s.sync2.data; // R2
                        next_s.fsm = HMP_DMA;
                    end else begin
                        next_s.acc_rw = s.as_valid ? s.as_rw : s.sync2.rw; // R6
                        next_s.acc_sel = s.as_valid ? s.as_sel : s.sync2.sel;
                        next_s.fsm = HMP_DONE;
                        case (next_s.acc_sel)
                            `HMP_SEL_CTRL: begin
                                if (next_s.acc_rw) begin
                                    next_s.out_data = ctrl_view; // R15
                                end else begin
                                    host_ctrl_wr = 1'b1;
                                    next_s.ext_sel = s.sync2.data[`HMP_CTRL_EXT_SEL]; // R15
                                    next_s.pref_en = s.sync2.data[`HMP_CTRL_PREF_EN];
                                    next_s.core_irq = s.sync2.data[`HMP_CTRL_CORE_IRQ]; // R11
                                end
                            end
                            `HMP_SEL_ADDR: begin
                                if (next_s.acc_rw) begin
                                    next_s.out_data = s.ext_sel ?
                                        {14'h0000, s.addr_reg[17:16]} : s.addr_reg[15:0];
                                end else begin
                                    if (s.ext_sel) begin
                                        next_s.addr_reg[17:16] = s.sync2.data[1:0]; // R5
                                    end else begin
                                        next_s.addr_reg[15:0] = s.sync2.data; // R5
                                    end
                                    next_s.pref_valid = 1'b0;
                                    // prefetch: fetch the new location before the host sees ready
                                    if (s.pref_en) begin // R15
                                        next_s.acc_pref = 1'b1;
                                        next_s.dma.valid = 1'b1; // R9
                                        next_s.dma.we = 1'b0;
                                        next_s.dma.addr = next_s.addr_reg;
                                        next_s.fsm = HMP_DMA;
                                    end
                                end
                            end
                            default: begin
                                next_s.acc_inc = (next_s.acc_sel == `HMP_SEL_DATA_INC);
                                if (next_s.acc_rw && s.pref_valid) begin
                                    next_s.out_data = s.pref_data;
                                    next_s.pref_valid = 1'b0;
                                    if (next_s.acc_inc) begin
                                        next_s.addr_reg = s.addr_reg + 18'h0_0001; // R5
                                    end
                                end else begin
                                    next_s.pref_valid = 1'b0;
                                    next_s.dma.valid = 1'b1; // R9
                                    next_s.dma.we = !next_s.acc_rw;
                                    next_s.dma.addr = s.addr_reg;
                                    next_s.dma.wdata = s.sync2.data; // R2
                                    next_s.fsm = HMP_DMA;
                                end
                            end
                        endcase
                    end
                end
            end
            HMP_DMA: begin
                // ready stays low until the channel answers
                if (aux_dma_ack) begin // R10
                    next_s.dma.valid = 1'b0;
                    if (s.acc_pref) begin
                        next_s.pref_data = aux_dma_rdata;
                        next_s.pref_valid = 1'b1;
                    end else if (s.acc_rw) begin
                        next_s.out_data = aux_dma_rdata;
                    end
                    if (s.acc_inc) begin
                        next_s.addr_reg = s.addr_reg + 18'h0_0001; // R5
                    end
                    next_s.fsm = HMP_DONE;
                end
            end
            HMP_DONE: begin
                // wait for the host to drop its strobe before the next access
                if (!strobe) begin // R20
                    next_s.fsm = HMP_IDLE;
                end
            end
            default: begin
                next_s.fsm = HMP_IDLE;
            end
        endcase
        next_s.out_oe = (next_s.fsm == HMP_DONE) && next_s.acc_rw && strobe; // R2

        // dsp side of the control register over the bus
        dsp_ctrl_wr = s.bus_wr && ((s.bus_addr & `HMP_ADDR_DEC_MASK) == `HMP_OFS_CTRL);
        if (dsp_ctrl_wr && !host_ctrl_wr) begin
            next_s.ext_sel = hwdata[`HMP_CTRL_EXT_SEL]; // R15
            next_s.pref_en = hwdata[`HMP_CTRL_PREF_EN];
        end
        // host clear by writing one; a fresh dsp set wins over the clear
        if (host_ctrl_wr && s.sync2.data[`HMP_CTRL_HOST_IRQ]) begin // R14
            next_s.host_irq = 1'b0;
        end
        if (dsp_ctrl_wr && hwdata[`HMP_CTRL_HOST_IRQ]) begin // R13
            next_s.host_irq = 1'b1;
        end

        // bus address phase
        next_s.bus_wr = 1'b0;
        if (hsel && hready && htrans == `HMP_HTRANS_NONSEQ) begin
            next_s.bus_addr = haddr;
            next_s.bus_wr = hwrite && (hsize == `HMP_HSIZE_WORD);
            if ((haddr & `HMP_ADDR_DEC_MASK) == `HMP_OFS_CTRL) begin
                next_s.hrdata = {16'h0000, ctrl_view}; // R12
            end else if ((haddr & `HMP_ADDR_DEC_MASK) == `HMP_OFS_STATUS) begin
                next_s.hrdata = 32'h0000_0000;
                next_s.hrdata[`HMP_ADDR_W-1:0] = s.addr_reg;
                next_s.hrdata[`HMP_STAT_BUSY] = (s.fsm != HMP_IDLE);
                next_s.hrdata[`HMP_STAT_MUX] = mux_mode;
                next_s.hrdata[`HMP_STAT_PREF_VALID] = s.pref_valid;
            end else begin
                next_s.hrdata = 32'h0000_0000;
            end
        end
    end

    // ==========================================
    // state register; rst is the port's own reset pin, kept apart from the core reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin // R17
            s <= '0;
            s.sync1.cs_n <= 1'b1;
            s.sync2.cs_n <= 1'b1;
            s.sync1.ds1_n <= 1'b1;
            s.sync2.ds1_n <= 1'b1;
            s.sync1.ds2_n <= 1'b1;
            s.sync2.ds2_n <= 1'b1;
            s.sync1.as_n <= 1'b1;
            s.sync2.as_n <= 1'b1;
            s.fsm <= HMP_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================
    // outputs
    assign host_data_bus_out = s.out_data;
    assign host_data_bus_oe = s.out_oe; // R2
    assign host_wait_ready = (s.fsm == HMP_DONE); // R10
    assign host_irq_n = !s.host_irq; // R13
    assign core_irq_request = s.core_irq; // R11 R21
    // the request carries only a memory address: no i/o space select exists
    assign aux_dma_req = s.dma; // R1 R19
    // in sleep the memory clocks run only while a transfer is in flight
    assign mem_clk_en = !(light_sleep || deeper_sleep) || s.dma.valid; // R16
    assign hreadyout = 1'b1;
    assign hresp = `HMP_HRESP_OKAY;
    assign hrdata = s.hrdata;

    // ==========================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_ready_after_ack: assert property ( // R10
        aux_dma_req.valid && aux_dma_ack |=> host_wait_ready
    ) else $error("ready not raised after dma answer");

    a_ready_held_off: assert property ( // R10
        aux_dma_req.valid |-> !host_wait_ready
    ) else $error("ready raised while dma pending");

    a_core_one_pulse: assert property ( // R21
        core_irq_request |=> !core_irq_request
    ) else $error("core interrupt longer than one cycle");

    a_core_from_write: assert property ( // R11
        host_ctrl_wr && s.sync2.data[`HMP_CTRL_CORE_IRQ] |=> core_irq_request
    ) else $error("core interrupt missing after host write");

    a_core_reads_zero: assert property ( // R12
        !hrdata[`HMP_CTRL_CORE_IRQ] || s.bus_addr[2]
    ) else $error("core interrupt bit read as one");

    a_host_irq_set: assert property ( // R13
        dsp_ctrl_wr && hwdata[`HMP_CTRL_HOST_IRQ] |=> !host_irq_n
    ) else $error("host interrupt not asserted");

    a_host_irq_zero_write: assert property ( // R14
        dsp_ctrl_wr && !hwdata[`HMP_CTRL_HOST_IRQ] && !host_ctrl_wr |=> $stable(host_irq_n)
    ) else $error("zero write changed host interrupt");

    a_host_irq_host_clear: assert property ( // R14
        host_ctrl_wr && s.sync2.data[`HMP_CTRL_HOST_IRQ] &&
        !(dsp_ctrl_wr && hwdata[`HMP_CTRL_HOST_IRQ]) |=> host_irq_n
    ) else $error("host clear ignored");

    a_no_ctrl_sep: assert property ( // R8
        !mux_mode |-> !host_ctrl_wr
    ) else $error("control written in separate mode");

    a_oe_on_read: assert property ( // R2
        host_data_bus_oe |-> s.acc_rw && host_wait_ready
    ) else $error("data bus driven outside a read");

    a_sep_addr: assert property ( // R4
        $rose(aux_dma_req.valid) && !mux_mode |-> aux_dma_req.addr == $past(s.sync2.addr)
    ) else $error("separate mode address not taken from bus");

    a_auto_inc: assert property ( // R5
        s.fsm == HMP_DMA && aux_dma_ack && s.acc_inc |=>
        s.addr_reg == $past(s.addr_reg) + 18'h0_0001
    ) else $error("address did not step");

    a_clk_on_access: assert property ( // R16
        aux_dma_req.valid |-> mem_clk_en
    ) else $error("memory clock off during access");

    a_dma_req_held: assert property ( // R9
        aux_dma_req.valid && !aux_dma_ack |=> aux_dma_req.valid && $stable(aux_dma_req.addr)
    ) else $error("dma request dropped before its answer");

    a_core_only_host: assert property ( // R11
        core_irq_request |-> $past(host_ctrl_wr)
    ) else $error("core interrupt without host write");

    a_ready_drops: assert property ( // R10
        host_wait_ready && !strobe |=> !host_wait_ready
    ) else $error("ready held after strobe release");

    c_mux_write: cover property (
        s.fsm == HMP_DMA && mux_mode && aux_dma_req.we ##[1:20] host_wait_ready
    );
    c_sep_read: cover property (
        s.fsm == HMP_DMA && !mux_mode && !aux_dma_req.we ##[1:20] host_data_bus_oe
    );
    c_pref_hit: cover property (
        s.pref_valid && strobe_rise && mux_mode
    );
    c_host_irq: cover property (
        $fell(host_irq_n) ##[1:200] $rose(host_irq_n)
    );
    c_addr_latch: cover property (
        strobe_rise && s.as_valid && mux_mode
    );

endmodule

// >>> testbench/hmp_host_model.sv
`timescale 1ns/1ps

module hmp_host_model
    import hmp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic ready,
    input wire logic dev_oe,
    input wire logic [15:0] dev_data,
    output logic cs_n,
    output logic ds1_n,
    output logic ds2_n,
    output logic rw,
    output logic as_n,
    output logic [1:0] sel,
    output logic [17:0] addr,
    output logic [15:0] bus
);
    logic drv;
    logic [15:0] wdata;

    initial begin
        cs_n = 1'b1;
        ds1_n = 1'b1;
        ds2_n = 1'b1;
        rw = 1'b1;
        as_n = 1'b1;
        sel = 2'h3;
        addr = 18'h0_0000;
        drv = 1'b0;
        wdata = 16'h0000;
    end

    // ==========================================
    // bus level
    // a released bus shows the inverse of the last word, so stale data cannot pass
    assign bus = dev_oe ? dev_data : (drv ? wdata : ~wdata);

    // ==========================================
    // one strobed access; writes strobe with one line, reads with the other
    task automatic access(input logic r, input logic [1:0] s, input logic [17:0] a,
                          input logic [15:0] wd, output logic [15:0] rd);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        ds1_n <= r;
        ds2_n <= !r;
        rw <= r;
        sel <= s;
        addr <= a;
        wdata <= wd;
        drv <= !r;
        // pins stay put until ready is sampled high; only the bench watchdog ends a hang
        do @(posedge clk_sys); while (ready !== 1'b1);
        // read the pin level so a missing output enable shows as the inverted word
        rd = bus;
        cs_n <= 1'b1;
        ds1_n <= 1'b1;
        ds2_n <= 1'b1;
        drv <= 1'b0;
        do @(posedge clk_sys); while (ready !== 1'b0);
    endtask

    // address strobe alone: latches select and direction for the next access
    task automatic addr_latch(input logic r, input logic [1:0] s);
        @(posedge clk_sys);
        as_n <= 1'b0;
        sel <= s;
        rw <= r;
        repeat (4) @(posedge clk_sys);
        as_n <= 1'b1;
    endtask
endmodule

// >>> testbench/tb_hmp_host_port.sv
`timescale 1ns/1ps
`include "hmp_defs.svh"

module tb_hmp_host_port;
    import hmp_pkg::*;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic port_mux_select = 1'b1;
    logic host_chip_select_n, data_strobe_one_n, data_strobe_two_n, host_read_write;
    logic host_addr_strobe_n;
    logic [1:0] reg_select_lines;
    logic [17:0] host_addr_bus;
    logic [15:0] host_data_bus_in, host_data_bus_out, aux_dma_rdata = 16'h0000;
    logic host_data_bus_oe, host_wait_ready, host_irq_n, core_irq_request, mem_clk_en;
    hmp_dma_req_type aux_dma_req;
    logic aux_dma_ack = 1'b0;
    logic light_sleep = 1'b0;
    logic deeper_sleep = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp;
    logic [31:0] hrdata, rd32;
    logic [15:0] rd16;
    logic [15:0] mem [logic [17:0]];
    logic slow = 1'b0;
    int dly = 0;
    int irq_cnt = 0;
    int err_total = 0;
    int num_checks = 0;

    always #2 clk_sys = ~clk_sys;
    assign hready = hreadyout;

    hmp_host_port uut (.clk_sys, .rst, .port_mux_select, .host_chip_select_n,
        .data_strobe_one_n, .data_strobe_two_n, .host_read_write, .host_addr_strobe_n,
        .reg_select_lines, .host_addr_bus, .host_data_bus_in, .host_data_bus_out,
        .host_data_bus_oe, .host_wait_ready, .host_irq_n, .core_irq_request, .aux_dma_req,
        .aux_dma_ack, .aux_dma_rdata, .light_sleep, .deeper_sleep, .mem_clk_en, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata);

    hmp_host_model host (.clk_sys(clk_sys), .ready(host_wait_ready),
        .dev_oe(host_data_bus_oe), .dev_data(host_data_bus_out), .cs_n(host_chip_select_n),
        .ds1_n(data_strobe_one_n), .ds2_n(data_strobe_two_n), .rw(host_read_write),
        .as_n(host_addr_strobe_n), .sel(reg_select_lines), .addr(host_addr_bus),
        .bus(host_data_bus_in));

    // ==========================================
    // aux channel memory: alternates prompt and slow answers
    always @(posedge clk_sys) begin
        aux_dma_ack <= 1'b0;
        aux_dma_rdata <= ~aux_dma_rdata;
        if (core_irq_request === 1'b1) irq_cnt++;
        if ((light_sleep || deeper_sleep) && aux_dma_req.valid === 1'b1 && mem_clk_en !== 1'b1)
            chk(32'h0, 32'h1);
        if (aux_dma_req.valid === 1'b1 && aux_dma_ack !== 1'b1) begin
            if (dly == 0) begin
                aux_dma_ack <= 1'b1;
                if (aux_dma_req.we) mem[aux_dma_req.addr] = aux_dma_req.wdata;
                aux_dma_rdata <= mem.exists(aux_dma_req.addr) ? mem[aux_dma_req.addr] : 16'h0;
                dly <= slow ? 0 : 5;
                slow <= ~slow;
            end else begin
                dly <= dly - 1;
            end
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0000_0000);
    endtask

    task automatic give_verdict();
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        err_total++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        chk({host_data_bus_oe, host_wait_ready, host_irq_n, aux_dma_req.valid}, 32'h2);
        // ==========================================
        // multiplexed: address register, low half then high bits
        host.access(1'b0, 2'h2, 18'h0, 16'h1234, rd16);
        host.access(1'b0, 2'h0, 18'h0, 16'h0001, rd16);
        host.access(1'b0, 2'h2, 18'h0, 16'h0002, rd16);
        host.access(1'b0, 2'h0, 18'h0, 16'h0000, rd16);
        ahb(1'b0, `HMP_OFS_STATUS, 32'h0, rd32);
        chk(rd32 & 32'h001F_FFFF, 32'h0008_0000 | 32'h0002_1234);
        host.access(1'b0, 2'h1, 18'h0, 16'hBEEF, rd16);
        host.access(1'b0, 2'h1, 18'h0, 16'hCAFE, rd16);
        chk({16'h0, mem[18'h2_1234]}, 32'h0000_BEEF);
        chk({16'h0, mem[18'h2_1235]}, 32'h0000_CAFE);
        host.access(1'b0, 2'h2, 18'h0, 16'h1235, rd16);
        host.access(1'b1, 2'h3, 18'h0, 16'h0, rd16);
        chk({16'h0, rd16}, 32'h0000_CAFE);
        ahb(1'b0, `HMP_OFS_STATUS, 32'h0, rd32);
        chk(rd32 & 32'h0003_FFFF, 32'h0002_1235);
        host.access(1'b1, 2'h1, 18'h0, 16'h0, rd16);
        chk({16'h0, rd16}, 32'h0000_CAFE);
        ahb(1'b0, `HMP_OFS_STATUS, 32'h0, rd32);
        chk(rd32 & 32'h0003_FFFF, 32'h0002_1236);
        // prefetch: the word fetched ahead must be served, not a fresh memory read
        host.access(1'b0, 2'h0, 18'h0, 16'h0010, rd16);
        host.access(1'b0, 2'h2, 18'h0, 16'h1234, rd16);
        mem[18'h2_1234] = 16'h0000;
        host.access(1'b1, 2'h1, 18'h0, 16'h0, rd16);
        chk({16'h0, rd16}, 32'h0000_BEEF);
        ahb(1'b0, `HMP_OFS_STATUS, 32'h0, rd32);
        chk(rd32 & 32'h0003_FFFF, 32'h0002_1235);
        // address strobe latches a data read; the select lines then say address
        host.addr_latch(1'b1, 2'h3);
        host.access(1'b1, 2'h2, 18'h0, 16'h0, rd16);
        chk({16'h0, rd16}, 32'h0000_CAFE);
        // ==========================================
        // mutual interrupts
        irq_cnt = 0;
        host.access(1'b0, 2'h0, 18'h0, 16'h0002, rd16);
        chk(irq_cnt, 32'h1);
        host.access(1'b1, 2'h0, 18'h0, 16'h0, rd16);
        chk({16'h0, rd16 & 16'h0017}, 32'h0);
        ahb(1'b0, `HMP_OFS_CTRL, 32'h0, rd32);
        chk(rd32 & 32'h0000_0002, 32'h0);
        ahb(1'b1, `HMP_OFS_CTRL, 32'h0000_0004, rd32);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, host_irq_n}, 32'h0);
        ahb(1'b1, `HMP_OFS_CTRL, 32'h0, rd32);
        host.access(1'b0, 2'h0, 18'h0, 16'h0000, rd16);
        chk({31'h0, host_irq_n}, 32'h0);
        host.access(1'b0, 2'h0, 18'h0, 16'h0004, rd16);
        chk({31'h0, host_irq_n}, 32'h1);
        ahb(1'b0, 32'h0000_0040, 32'h0, rd32);
        chk(rd32, 32'h0);
        // ==========================================
        // separate buses, asleep; a control select still lands in memory
        port_mux_select <= 1'b0;
        light_sleep <= 1'b1;
        repeat (4) @(posedge clk_sys);
        host.access(1'b0, 2'h0, 18'h3_ABCD, 16'h5A5A, rd16);
        chk({16'h0, mem[18'h3_ABCD]}, 32'h0000_5A5A);
        deeper_sleep <= 1'b1;
        host.access(1'b1, 2'h0, 18'h3_ABCD, 16'h0, rd16);
        chk({16'h0, rd16}, 32'h0000_5A5A);
        chk({31'h0, mem_clk_en}, 32'h0);
        chk(irq_cnt, 32'h1);
        ahb(1'b0, `HMP_OFS_STATUS, 32'h0, rd32);
        chk(rd32 & 32'h0008_0000, 32'h0);
        give_verdict();
    end
endmodule
